/* swpos_unit.sv */
// Purpose: Supervises one switching element.
// Assumes: Contact inputs already synchronised; one-cycle requests.
// Notes: A travel timer validates each movement and limits the drive.
`timescale 1ns/10ps
module swpos_unit
    import swpos_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_aux_close,
    input wire logic i_aux_open,
    input wire logic [1:0] i_wired,
    input wire logic i_force_open,
    input wire logic i_close_req,
    input wire logic i_open_req,
    input wire logic [TRAVEL_W-1:0] i_t_close,
    input wire logic [TRAVEL_W-1:0] i_t_open,
    output logic o_drive_close,
    output logic o_drive_open,
    output logic [1:0] o_pos
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CLOSING = 3'b010,
        ST_OPENING = 3'b100
    } move_t;

    move_t st_q, st_d;
    logic [TRAVEL_W-1:0] cnt_q, cnt_d;
    logic [1:0] pos_q, pos_d;
    logic expired_q, expired_d;
    logic is_closed, is_open, equal_in, running;

    // ------------------------------------------------------------------
    // Contact evaluation
    // ------------------------------------------------------------------
    // Single contact: absence of the wired contact means the other end
    always_comb begin
        is_closed = 1'b0;
        is_open = 1'b0;
        equal_in = 1'b0;
        if (i_wired == WIRE_BOTH) begin
            is_closed = i_aux_close & ~i_aux_open;
            is_open = ~i_aux_close & i_aux_open;
            equal_in = i_aux_close == i_aux_open;
        end else if (i_wired == WIRE_CLOSE_ONLY) begin // see (R19)
            is_closed = i_aux_close;
            is_open = ~i_aux_close;
        end else if (i_wired == WIRE_OPEN_ONLY) begin
            is_open = i_aux_open;
            is_closed = ~i_aux_open;
        end
    end

    assign running = st_q != ST_IDLE;

    // ------------------------------------------------------------------
    // Travel sequence
    // ------------------------------------------------------------------
    // Next state, timer and validated position
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        expired_d = expired_q;
        case (st_q)
            ST_IDLE: begin
                if (i_close_req && !i_force_open) begin
                    st_d = ST_CLOSING; // see (R2)
                    cnt_d = TRAVEL_RST;
                    expired_d = 1'b0;
                end else if (i_open_req) begin
                    st_d = ST_OPENING; // see (R5)
                    cnt_d = TRAVEL_RST;
                    expired_d = 1'b0;
                end
            end
            ST_CLOSING: begin
                if (is_closed || i_force_open) begin
                    st_d = ST_IDLE; // see (R3)
                end else if (cnt_q + 1'b1 >= i_t_close) begin
                    st_d = ST_IDLE; // see (R4) (R22)
                    expired_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_OPENING: begin
                if (is_open) begin
                    st_d = ST_IDLE; // see (R6)
                end else if (cnt_q + 1'b1 >= i_t_open) begin
                    st_d = ST_IDLE; // see (R6) (R22)
                    expired_d = 1'b1;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // Position from contacts, timer state and withdrawal
        if (i_force_open) begin
            pos_d = POS_OPEN; // see (R14) (R15)
        end else if (i_wired == 2'h0) begin
            pos_d = POS_DISTURB;
        end else if (st_d == ST_CLOSING && !is_closed) begin
            // Old end position no longer counts once travel has begun
            pos_d = POS_INDETERM; // see (R2) (R9)
        end else if (st_d == ST_OPENING && !is_open) begin
            pos_d = POS_INDETERM; // see (R5) (R9)
        end else if (is_open) begin
            pos_d = POS_OPEN; // see (R10)
        end else if (is_closed) begin
            pos_d = POS_CLOSED; // see (R10)
        end else if (equal_in) begin
            pos_d = POS_DISTURB; // see (R11)
        end else begin
            pos_d = POS_INDETERM;
        end
        if (expired_d && !is_open && !is_closed && !i_force_open) begin
            pos_d = POS_DISTURB; // see (R4)
        end
    end

    // Register the travel sequence
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= TRAVEL_RST;
            pos_q <= POS_INDETERM;
            expired_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pos_q <= pos_d;
            expired_q <= expired_d;
        end
    end

    // Drives end on position or timer expiry
    assign o_drive_close = st_q == ST_CLOSING; // see (R7)
    assign o_drive_open = st_q == ST_OPENING; // see (R8)
    assign o_pos = pos_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    drive_excl_a: assert property ( // see (R7) (R8)
        @(posedge i_clk) disable iff (!i_rst_n)
        !(o_drive_close && o_drive_open))
        else $error("both drives asserted");
    close_start_a: assert property ( // see (R2)
        @(posedge i_clk) disable iff (!i_rst_n)
        (st_q == ST_IDLE && i_close_req && !i_force_open)
        |=> (o_drive_close && o_pos == POS_INDETERM) || is_closed)
        else $error("close request did not start travel");
    close_done_a: assert property ( // see (R3)
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_drive_close && is_closed && !i_force_open)
        |=> !o_drive_close && o_pos == POS_CLOSED)
        else $error("closed position not shown");
    open_start_a: assert property ( // see (R5)
        @(posedge i_clk) disable iff (!i_rst_n)
        (st_q == ST_IDLE && i_open_req && !i_close_req && !is_open)
        |=> o_drive_open)
        else $error("open request did not start travel");
    open_done_a: assert property ( // see (R8)
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_drive_open && is_open) |=> !o_drive_open)
        else $error("open drive not released");
    force_open_a: assert property ( // see (R14)
        @(posedge i_clk) disable iff (!i_rst_n)
        i_force_open |=> o_pos == POS_OPEN)
        else $error("withdrawn unit not open");
    close_limit_a: assert property ( // see (R7)
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_drive_close && cnt_q + 1'b1 >= i_t_close)
        |=> !o_drive_close)
        else $error("close drive too long");
    disturb_a: assert property ( // see (R4)
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_drive_open && !is_open && !is_closed && cnt_q + 1'b1 >= i_t_open
         && !i_force_open) |=> o_pos == POS_DISTURB)
        else $error("expiry not flagged");
endmodule : swpos_unit

/* swpos_pkg.sv */
// Purpose: Shared constants for the switchgear position supervisor.
// Assumes: 25 MHz system clock.
// Notes: Position codes, counter widths and default travel times.
package swpos_pkg;
    // ------------------------------------------------------------------
    // Position codes
    // ------------------------------------------------------------------
    localparam logic [1:0] POS_INDETERM = 2'h0;
    localparam logic [1:0] POS_OPEN = 2'h1;
    localparam logic [1:0] POS_CLOSED = 2'h2;
    localparam logic [1:0] POS_DISTURB = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int TRAVEL_W = 24;
    localparam int TRAVEL_DEF_MS = 100;
    localparam logic [TRAVEL_W-1:0] TRAVEL_DEF_CYC =
        TRAVEL_W'(TRAVEL_DEF_MS * (CLK_HZ / 1000));
    localparam logic [TRAVEL_W-1:0] TRAVEL_RST = 24'h000000;

    // Contact wiring selections
    localparam logic [1:0] WIRE_BOTH = 2'h3;
    localparam logic [1:0] WIRE_CLOSE_ONLY = 2'h2;
    localparam logic [1:0] WIRE_OPEN_ONLY = 2'h1;
endpackage : swpos_pkg

/* swpos_top.sv */
// Purpose: Position supervisor for a withdrawable switching unit.
// Assumes: Contact and plug pins are asynchronous; 25 MHz clock.
// Notes: Switching part and truck are two supervised elements.
//
// Operation
// (R1) Position code 0..3: indeterminate, open, closed, disturbed
// (R2) Close request starts timer, shows indeterminate
// (R3) Closed before expiry shows closed
// (R4) Expiry without new position shows disturbed; code shows the old end position while its contacts still decode it
// (R5) Open request starts timer, shows indeterminate
// (R6) Open before expiry shows open, else disturbed; code shows closed if the contacts still decode closed
// (R7) Close drive limited to close travel time
// (R8) Open drive limited to open travel time
// (R9) Equal contacts while running: indeterminate
// (R10) Contact pairs decode to open or closed
// (R11) Equal contacts after expiry: disturbed
// (R12) Both contacts sampled continuously
// (R13) Plug removal asserts withdrawn status
// (R14) Withdrawn forces switching part open
// (R15) Overrides of withdrawn unit ignored
// (R16) Withdrawable unit is part plus truck
// (R17) Interlock prevents withdrawing a closed part
// (R18) Installation wires at least one contact
// (R19) Single contact gives reduced supervision
// (R20) Protection commands share control relays
// (R21) Travel times set per element
// (R22) Travel times are clock cycle counts
`timescale 1ns/10ps
module swpos_top
    import swpos_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_part_aux_close,
    input wire logic i_part_aux_open,
    input wire logic i_truck_aux_close,
    input wire logic i_truck_aux_open,
    input wire logic i_plug_removed,
    input wire logic [1:0] i_part_wired,
    input wire logic [1:0] i_truck_wired,
    input wire logic i_part_close_req,
    input wire logic i_part_open_req,
    input wire logic i_prot_close_req,
    input wire logic i_prot_open_req,
    input wire logic i_truck_close_req,
    input wire logic i_truck_open_req,
    input wire logic i_pos_override,
    input wire logic [TRAVEL_W-1:0] i_part_t_close,
    input wire logic [TRAVEL_W-1:0] i_part_t_open,
    input wire logic [TRAVEL_W-1:0] i_truck_t_close,
    input wire logic [TRAVEL_W-1:0] i_truck_t_open,
    output logic o_part_drive_close,
    output logic o_part_drive_open,
    output logic o_truck_drive_close,
    output logic o_truck_drive_open,
    output logic [1:0] o_part_pos,
    output logic o_part_closed,
    output logic o_part_open,
    output logic o_part_indeterm,
    output logic o_part_disturb,
    output logic [1:0] o_truck_pos,
    output logic o_withdrawn,
    output logic o_interlock_block
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    localparam int NSYNC = 5;
    logic [NSYNC-1:0] raw_in, s1_q, s1_d, s2_q, s2_d;
    logic p_close, p_open, t_close, t_open, removed;

    assign raw_in = {i_plug_removed, i_truck_aux_open, i_truck_aux_close,
                     i_part_aux_open, i_part_aux_close};

    // Two stages for every pin input
    always_comb begin
        s1_d = raw_in; // see (R12)
        s2_d = s1_q;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign {removed, t_open, t_close, p_open, p_close} = s2_q;

    // ------------------------------------------------------------------
    // Command merging and interlock
    // ------------------------------------------------------------------
    logic part_close_cmd, part_open_cmd, truck_close_cmd, truck_open_cmd;
    logic wd_q, wd_d;

    // Protection and control commands drive the same relays
    assign part_close_cmd = i_part_close_req | i_prot_close_req; // see (R20)
    assign part_open_cmd = i_part_open_req | i_prot_open_req; // see (R20)
    // Truck moving out is refused while the part is closed
    assign truck_open_cmd = i_truck_open_req &
                            (o_part_pos != POS_CLOSED); // see (R17)
    assign truck_close_cmd = i_truck_close_req;
    assign o_interlock_block = o_part_pos == POS_CLOSED; // see (R17)

    // Withdrawn status follows the plug; overrides have no path
    always_comb begin
        wd_d = removed; // see (R13) (R15)
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wd_q <= 1'b0;
        end else begin
            wd_q <= wd_d;
        end
    end

    assign o_withdrawn = wd_q;

    // ------------------------------------------------------------------
    // Supervised elements
    // ------------------------------------------------------------------
    // Switching part, with withdrawal forcing open
    swpos_unit u_part (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_aux_close(p_close),
        .i_aux_open(p_open),
        .i_wired(i_part_wired),
        .i_force_open(wd_q), // see (R14)
        .i_close_req(part_close_cmd),
        .i_open_req(part_open_cmd),
        .i_t_close(i_part_t_close), // see (R21)
        .i_t_open(i_part_t_open),
        .o_drive_close(o_part_drive_close),
        .o_drive_open(o_part_drive_open),
        .o_pos(o_part_pos)
    );

    // Truck uses only its two contacts, no plug input
    swpos_unit u_truck (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_aux_close(t_close),
        .i_aux_open(t_open),
        .i_wired(i_truck_wired),
        .i_force_open(1'b0), // see (R16)
        .i_close_req(truck_close_cmd),
        .i_open_req(truck_open_cmd),
        .i_t_close(i_truck_t_close), // see (R21)
        .i_t_open(i_truck_t_open),
        .o_drive_close(o_truck_drive_close),
        .o_drive_open(o_truck_drive_open),
        .o_pos(o_truck_pos)
    );

    // ------------------------------------------------------------------
    // Indications
    // ------------------------------------------------------------------
    // One indication per code value
    assign o_part_indeterm = o_part_pos == POS_INDETERM; // see (R1)
    assign o_part_open = o_part_pos == POS_OPEN; // see (R1)
    assign o_part_closed = o_part_pos == POS_CLOSED; // see (R1)
    assign o_part_disturb = o_part_pos == POS_DISTURB; // see (R1)

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    withdrawn_follow_a: assert property ( // see (R13)
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(removed) |=> o_withdrawn)
        else $error("withdrawn status missing");
    withdrawn_open_a: assert property ( // see (R14)
        @(posedge i_clk) disable iff (!i_rst_n)
        o_withdrawn |=> o_part_open)
        else $error("withdrawn part not open");
    override_ignored_a: assert property ( // see (R15)
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_withdrawn && wd_d && i_pos_override) |=> o_part_open)
        else $error("override changed withdrawn unit");
    truck_lock_a: assert property ( // see (R17)
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_part_closed && !o_truck_drive_open) |=> !o_truck_drive_open)
        else $error("truck moved while part closed");
    prot_relay_a: assert property ( // see (R20)
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_prot_open_req && !o_part_drive_close && !o_part_drive_open
         && !i_prot_close_req && !i_part_close_req && !o_part_open)
        |=> o_part_drive_open || o_part_open)
        else $error("protection open not on relay");
    onehot_ind_a: assert property ( // see (R1)
        @(posedge i_clk) disable iff (!i_rst_n)
        $onehot({o_part_indeterm, o_part_open, o_part_closed,
                 o_part_disturb}))
        else $error("indications not exclusive");
endmodule : swpos_top

/* swpos_contacts.sv */
// Purpose: Auxiliary contact pair of one switching element.
// Assumes: Contacts travel a set number of cycles after a drive.
// Notes: Stuck freezes the travel half way, on command only.
`timescale 1ns/10ps
module swpos_contacts (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_drive_close,
    input wire logic i_drive_open,
    input wire logic [7:0] i_delay,
    input wire logic i_stuck,
    input wire logic i_mid_both,
    output logic o_aux_close,
    output logic o_aux_open
);
    logic closed_q, closed_d, moving_q, moving_d;
    logic [7:0] cnt_q, cnt_d;

    // Travel after a drive toward the other end position
    always_comb begin
        closed_d = closed_q;
        moving_d = moving_q;
        cnt_d = cnt_q;
        if (!moving_q && ((i_drive_close && !closed_q) ||
            (i_drive_open && closed_q))) begin
            moving_d = 1'b1;
            cnt_d = 8'h00;
        end else if (moving_q && !i_stuck) begin
            if (cnt_q >= i_delay) begin
                moving_d = 1'b0;
                closed_d = !closed_q;
            end else begin
                cnt_d = cnt_q + 8'h01;
            end
        end
    end

    // Register the contact state
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            moving_q <= 1'b0;
            cnt_q <= 8'h00;
            closed_q <= 1'b0;
        end else begin
            moving_q <= moving_d;
            cnt_q <= cnt_d;
            closed_q <= closed_d;
        end
    end

    // Both contacts wired, equal in mid travel
    assign o_aux_close = moving_q ? i_mid_both : closed_q;
    assign o_aux_open = moving_q ? i_mid_both : !closed_q;
endmodule : swpos_contacts

/* test_switchgear_position_supervisor.sv */
// Purpose: Self-checking bench for the position supervisor.
// Assumes: Contact models answer each drive after a delay, random for the part, fixed for the truck.
// Notes: Random travel times and moves from a fixed seed.
`timescale 1ns/10ps
module test_switchgear_position_supervisor;
    import swpos_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, plug = 1'b0, ovr = 1'b0;
    logic pac, pao, tac, tao, pdc, pdo, tdc, tdo, wd, ilk;
    logic pcl, pop, pind, pdis;
    logic pcr = 0, por = 0, xcr = 0, xor_r = 0, tcr = 0, tor = 0;
    logic p_stuck = 0, t_stuck = 0, p_mid = 0, t_mid = 0;
    logic [1:0] pw = WIRE_BOTH, tw = WIRE_BOTH, ppos, tpos, mid;
    logic [7:0] p_dly = 8'h05, t_dly = 8'h05;
    logic [TRAVEL_W-1:0] pt_c = 24'h000028, pt_o = 24'h000028;
    logic [TRAVEL_W-1:0] tt_c = 24'h000030, tt_o = 24'h000030;
    int error_cnt = 0, checks = 0, len, n;
    int unsigned seed_v;

    // ------------------------------------------------------------------
    // Clock, design and contact models
    // ------------------------------------------------------------------
    always #20 i_clk = !i_clk;

    swpos_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_part_aux_close(pac), .i_part_aux_open(pao),
        .i_truck_aux_close(tac), .i_truck_aux_open(tao),
        .i_plug_removed(plug), .i_part_wired(pw), .i_truck_wired(tw),
        .i_part_close_req(pcr), .i_part_open_req(por),
        .i_prot_close_req(xcr), .i_prot_open_req(xor_r),
        .i_truck_close_req(tcr), .i_truck_open_req(tor),
        .i_pos_override(ovr), .i_part_t_close(pt_c),
        .i_part_t_open(pt_o), .i_truck_t_close(tt_c),
        .i_truck_t_open(tt_o), .o_part_drive_close(pdc),
        .o_part_drive_open(pdo), .o_truck_drive_close(tdc),
        .o_truck_drive_open(tdo), .o_part_pos(ppos),
        .o_part_closed(pcl), .o_part_open(pop),
        .o_part_indeterm(pind), .o_part_disturb(pdis),
        .o_truck_pos(tpos), .o_withdrawn(wd), .o_interlock_block(ilk));

    swpos_contacts part_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_drive_close(pdc), .i_drive_open(pdo), .i_delay(p_dly),
        .i_stuck(p_stuck), .i_mid_both(p_mid),
        .o_aux_close(pac), .o_aux_open(pao));

    swpos_contacts truck_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_drive_close(tdc), .i_drive_open(tdo), .i_delay(t_dly),
        .i_stuck(t_stuck), .i_mid_both(t_mid),
        .o_aux_close(tac), .o_aux_open(tao));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic step();
        @(posedge i_clk);
        #1;
    endtask : step

    task automatic chk(input string what, input logic [23:0] exp,
        input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // Expected indication flags {disturb, closed, open, indeterm}
    function automatic logic [3:0] flags(input logic [1:0] code);
        return 4'h1 << code;
    endfunction : flags

    function automatic logic drv(input bit tr, input bit cl);
        return tr ? (cl ? tdc : tdo) : (cl ? pdc : pdo);
    endfunction : drv

    // Wait a bounded time for a position code, then compare it
    task automatic wait_pos(input bit tr, input logic [1:0] exp);
        for (n = 0; n < 60 && (tr ? tpos : ppos) !== exp; n++) step();
        chk(tr ? "truck_pos" : "part_pos", exp, tr ? tpos : ppos);
        if (!tr) chk("part_flags", flags(exp), {pdis, pcl, pop, pind});
        // A timeout has already been counted by the compare above
        if ((tr ? tpos : ppos) !== exp) finish_test();
    endtask : wait_pos

    // One request pulse, then measure how long the drive stands
    task automatic move(input bit tr, input bit cl, input bit prot);
        len = 0;
        mid = 2'h3;
        if (tr) {tcr, tor} = {cl, !cl};
        else if (prot) {xcr, xor_r} = {cl, !cl};
        else {pcr, por} = {cl, !cl};
        step();
        {pcr, por, xcr, xor_r, tcr, tor} = 6'h00;
        for (n = 0; n < 3 && !drv(tr, cl); n++) step();
        while (drv(tr, cl) && len < 300) begin
            len++;
            if (len == 2) mid = tr ? tpos : ppos;
            step();
        end
        if (len == 300) begin
            error_cnt++;
            finish_test();
        end
    endtask : move

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed_v = $urandom(32'h15E4);
        repeat (3) step();
        chk("reset_pos", POS_INDETERM, ppos);
        chk("reset_out", 24'h0, {pdc, pdo, tdc, tdo, wd});
        i_rst_n = 1'b1;
        wait_pos(0, POS_OPEN);
        // Random close and open moves, ending open
        for (int i = 0; i < 6; i++) begin
            p_dly = 8'(3 + $urandom % 18);
            p_mid = 1'($urandom);
            pt_c = TRAVEL_W'(40 + $urandom % 41);
            pt_o = TRAVEL_W'(40 + $urandom % 41);
            move(0, i % 2 == 0, 1'($urandom));
            chk("mid_pos", POS_INDETERM, mid);
            chk("drv_short", 1,
                len > 0 && len <= (i % 2 == 0 ? pt_c : pt_o));
            wait_pos(0, i % 2 == 0 ? POS_CLOSED : POS_OPEN);
        end
        // Contacts stuck in mid travel: full drive, then disturbed
        p_stuck = 1'b1;
        pt_c = 24'h00001E;
        move(0, 1, 0);
        chk("drv_full", pt_c, len);
        wait_pos(0, POS_DISTURB);
        p_stuck = 1'b0;
        wait_pos(0, POS_CLOSED);
        // Truck moves on its own times; opening refused while closed
        t_dly = 8'h0A;
        move(1, 1, 0);
        chk("truck_drv", 1, len > 0 && len <= tt_c);
        wait_pos(1, POS_CLOSED);
        chk("interlock", 1, ilk);
        move(1, 0, 0);
        chk("truck_refused", 0, len);
        wait_pos(1, POS_CLOSED);
        // Plug removed: forced open, overrides and close ignored
        plug = 1'b1;
        for (n = 0; n < 8 && wd !== 1'b1; n++) step();
        chk("withdrawn", 1, wd);
        wait_pos(0, POS_OPEN);
        ovr = 1'b1;
        repeat (4) step();
        chk("override", POS_OPEN, ppos);
        move(0, 1, 0);
        chk("close_wd", 0, len);
        {plug, ovr} = 2'h0;
        wait_pos(0, POS_CLOSED);
        move(0, 0, 0);
        wait_pos(0, POS_OPEN);
        chk("interlock_off", 0, ilk);
        move(1, 0, 0);
        wait_pos(1, POS_OPEN);
        // Wiring choices with the part resting open
        for (int w = 3; w >= 0; w--) begin
            pw = 2'(w);
            repeat (4) step();
            wait_pos(0, w == 0 ? POS_DISTURB : POS_OPEN);
        end
        pw = WIRE_CLOSE_ONLY;
        move(0, 1, 0);
        wait_pos(0, POS_CLOSED);
        // Protection open into stuck contacts: full drive, then disturbed
        pw = WIRE_BOTH;
        p_stuck = 1'b1;
        move(0, 0, 1);
        chk("drv_full_open", pt_o, len);
        wait_pos(0, POS_DISTURB);
        finish_test();
    end
endmodule : test_switchgear_position_supervisor
